// [core/sblo_core.sv]
// Execution core for skip-on-zero counts, page branch and inclusive OR.
// Assumes decoded operations arrive on core_clk with a valid and ready handshake.
//
// Notes on behaviour
// (RL1) Decrement file register, route by destination, flags untouched
// (RL2) Zero decrement result turns next instruction into no-op
// (RL3) Increment with skip on zero, flags untouched
// (RL4) Branch loads eleven-bit immediate into low PC
// (RL5) Branch page bits from latch; two cycles, no flags
// (RL6) OR literal into accumulator, zero flag only
// (RL7) OR accumulator with file, routed by destination
// (RL8) Zero flag set exactly when result is zero
`default_nettype none
module sblo_core
   import sblo_pkg::*;
#(
   parameter int DEPTH = FILE_DEPTH
) (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               instr_valid,
   output logic                    instr_ready,
   input  wire sblo_op_t           instr_op,
   input  wire logic [FADDR_W-1:0] instr_faddr,
   input  wire logic               instr_dest,
   input  wire logic [LIT_W-1:0]   instr_lit,
   input  wire logic [PAGE_W-1:0]  page_latch,
   output logic [DATA_W-1:0]       acc,
   output logic                    zero_flag,
   output logic [PC_W-1:0]         pc,
   output logic                    skip_pending,
   output logic [DATA_W-1:0]       result,
   output logic                    result_valid
);
   // Whole core state in one record
   typedef struct packed {
      sblo_state_t        state;   // Sequencing state
      sblo_op_t           op;      // Operation in flight
      logic [FADDR_W-1:0] faddr;   // File address in flight
      logic               dest;    // 1 = back to file, 0 = accumulator
      logic [DATA_W-1:0]  w;       // Accumulator
      logic               z;       // Zero flag
      logic [PC_W-1:0]    pc;      // Program counter
      logic               skip;    // Next instruction is squashed
      logic [DATA_W-1:0]  result;  // Last result
      logic               rvalid;  // Result pulse
   } sblo_core_t;

   sblo_core_t cur;      // Registered state
   sblo_core_t next_cur; // Next state

   sblo_mem_if mem_bus ();

   logic [DATA_W-1:0] dec_val;    // File operand minus one
   logic [DATA_W-1:0] inc_val;    // File operand plus one
   logic [DATA_W-1:0] orf_val;    // Accumulator OR file operand
   logic [DATA_W-1:0] orl_val;    // Accumulator OR literal
   logic [DATA_W-1:0] exec_val;   // Result chosen for the EXEC op
   logic [PC_W-1:0]   branch_pc;  // Assembled branch target
   logic              take;       // Instruction handshake

   sblo_file_mem #(.DEPTH(DEPTH), .WIDTH(DATA_W)) u_mem (
      .core_clk (core_clk),
      .bus      (mem_bus.mem)
   );

   // Only fixed-size file space is addressable
   if (DEPTH > FILE_DEPTH) begin : g_bad_depth
      $error("sblo_core: depth beyond file address range");
   end

   // True for ops that need a file operand
   function automatic logic uses_file(input sblo_op_t op);
      return (op == SBLO_DECSZ) || (op == SBLO_INCSZ) || (op == SBLO_ORF) ||
             (op == SBLO_INCREMENT_FILE_REGISTER);
   endfunction

   // Datapath values, the data ones all 8 bits so the wrap from 00 to ff is kept; branch target 13 bits
   assign dec_val   = mem_bus.rdata - 8'h01;                        // [RL1]
   assign inc_val   = mem_bus.rdata + 8'h01;                        // [RL3]
   assign orf_val   = cur.w | mem_bus.rdata;                        // [RL7]
   assign orl_val   = cur.w | instr_lit[DATA_W-1:0];                // [RL6]
   assign branch_pc = {page_latch[PAGE_SRC_HI:PAGE_SRC_LO],
                       instr_lit[PC_LOW_HI:0]};                     // [RL4] [RL5]
   assign take      = instr_valid && instr_ready;

   // Result selection for the write-back cycle
   always_comb begin
      case (cur.op)
         SBLO_DECSZ: exec_val = dec_val;
         SBLO_INCSZ: exec_val = inc_val;
         SBLO_INCREMENT_FILE_REGISTER:  exec_val = inc_val;
         SBLO_ORF:   exec_val = orf_val;
         default:    exec_val = cur.w;
      endcase
   end

   // Ready only between instructions; branch and squash cycles stall the source
   assign instr_ready = (cur.state == SBLO_IDLE);

   // Memory strobes: read on acceptance, write back in EXEC when dest is file
   assign mem_bus.addr  = (cur.state == SBLO_EXEC) ? cur.faddr : instr_faddr;
   assign mem_bus.rd_en = take && !cur.skip && uses_file(instr_op);
   assign mem_bus.wr_en = (cur.state == SBLO_EXEC) && cur.dest;     // [RL1] [RL7]
   assign mem_bus.wdata = exec_val;

   // Next state
   always_comb begin
      next_cur        = cur;
      next_cur.rvalid = 1'b0;
      case (cur.state)
         SBLO_IDLE: begin
            if (take && cur.skip) begin
               // Skipped slot: a no-operation cycle, only the program counter moves and the skip clears
               next_cur.skip  = 1'b0;                               // [RL2] [RL3]
               next_cur.pc    = cur.pc + 13'h0001;
               next_cur.state = SBLO_SQUASH;
            end else if (take) begin
               next_cur.op    = instr_op;
               next_cur.faddr = instr_faddr;
               next_cur.dest  = instr_dest;
               case (instr_op)
                  SBLO_BR: begin
                     next_cur.pc    = branch_pc;                    // [RL4] [RL5]
                     next_cur.state = SBLO_BRANCH;                  // [RL5]
                  end
                  SBLO_ORL: begin
                     next_cur.w      = orl_val;                     // [RL6]
                     next_cur.z      = (orl_val == 8'h00);          // [RL8]
                     next_cur.result = orl_val;
                     next_cur.rvalid = 1'b1;
                     next_cur.pc     = cur.pc + 13'h0001;
                  end
                  SBLO_NOP: begin
                     next_cur.pc = cur.pc + 13'h0001;
                  end
                  default: begin
                     // File operand comes out of the memory next edge
                     next_cur.pc    = cur.pc + 13'h0001;
                     next_cur.state = SBLO_EXEC;
                  end
               endcase
            end
         end
         SBLO_EXEC: begin
            next_cur.result = exec_val;
            next_cur.rvalid = 1'b1;
            if (!cur.dest) begin
               next_cur.w = exec_val;                               // [RL1] [RL3] [RL7]
            end
            // Counting skips leave the flags alone; the plain ops touch zero only
            if (cur.op == SBLO_ORF || cur.op == SBLO_INCREMENT_FILE_REGISTER) begin
               next_cur.z = (exec_val == 8'h00);                    // [RL7] [RL8]
            end
            if ((cur.op == SBLO_DECSZ || cur.op == SBLO_INCSZ) && exec_val == 8'h00) begin
               next_cur.skip = 1'b1;                                // [RL2] [RL3]
            end
            next_cur.state = SBLO_IDLE;
         end
         SBLO_BRANCH: begin
            next_cur.state = SBLO_IDLE;                             // [RL5]
         end
         SBLO_SQUASH: begin
            next_cur.state = SBLO_IDLE;
         end
         default: begin
            next_cur.state = SBLO_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cur        <= '0;
         cur.state  <= SBLO_IDLE;
         cur.op     <= SBLO_NOP;
         cur.w      <= W_RESET;
         cur.z      <= Z_RESET;
         cur.pc     <= PC_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from flops
   assign acc          = cur.w;
   assign zero_flag    = cur.z;
   assign pc           = cur.pc;
   assign skip_pending = cur.skip;
   assign result       = cur.result;
   assign result_valid = cur.rvalid;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic exec_dec;  // Decrement in write-back
   logic exec_inc;  // Increment-and-skip in write-back
   logic take_br;   // Branch taken this edge
   logic take_orl;  // OR literal taken this edge
   assign exec_dec = (cur.state == SBLO_EXEC) && (cur.op == SBLO_DECSZ);
   assign exec_inc = (cur.state == SBLO_EXEC) && (cur.op == SBLO_INCSZ);
   assign take_br  = take && !cur.skip && (instr_op == SBLO_BR);
   assign take_orl = take && !cur.skip && (instr_op == SBLO_ORL);

   dec_value_a: assert property (exec_dec |=> result == $past(dec_val) && result_valid &&
      zero_flag == $past(zero_flag))                                 // [RL1]
      else $error("decrement result or flag wrong");
   dec_route_a: assert property (exec_dec && !cur.dest |=> acc == $past(dec_val)) // [RL1]
      else $error("decrement not routed to accumulator");
   skip_set_a: assert property ((exec_dec || exec_inc) && exec_val == 8'h00 |=> // [RL2] [RL3]
      skip_pending && instr_ready)
      else $error("skip not armed on zero result");
   squash_a: assert property (take && cur.skip |=> cur.state == SBLO_SQUASH &&
      $stable(acc) && !result_valid ##1 instr_ready && !skip_pending) // [RL2]
      else $error("skipped instruction not squashed");
   inc_value_a: assert property (exec_inc |=> result == $past(inc_val) &&
      $stable(zero_flag) && (skip_pending == (result == 8'h00)))     // [RL3]
      else $error("increment skip wrong");
   branch_low_a: assert property (take_br |=> pc[PC_LOW_HI:0] ==
      $past(instr_lit[PC_LOW_HI:0]))                                 // [RL4]
      else $error("branch low bits wrong");
   branch_page_a: assert property (take_br |=> pc[PC_PAGE_HI:PC_PAGE_LO] ==
      $past(page_latch[PAGE_SRC_HI:PAGE_SRC_LO]) && !instr_ready &&
      $stable(zero_flag) ##1 instr_ready)                            // [RL5]
      else $error("branch page or length wrong");
   or_lit_a: assert property (take_orl |=> acc == $past(orl_val))  // [RL6]
      else $error("literal OR wrong");
   or_file_a: assert property ((cur.state == SBLO_EXEC) && (cur.op == SBLO_ORF) &&
      !cur.dest |=> acc == $past(orf_val))                           // [RL7]
      else $error("file OR not in accumulator");
   // Every pulse except the counting skips is checked, so back-to-back literal ORs are covered too
   zero_rule_a: assert property (result_valid && cur.op != SBLO_DECSZ && // [RL8]
      cur.op != SBLO_INCSZ |-> zero_flag == (result == 8'h00))
      else $error("zero flag does not match result");
endmodule : sblo_core
`default_nettype wire

// [core/sblo_pkg.sv]
// Package for the skip, branch and OR execution core.
// Holds the opcodes, the core states, the field widths and the reset values.
// Assumes that a fetch or decode stage outside the core supplies decoded opcodes.
`default_nettype none
package sblo_pkg;
   // Field widths
   localparam int DATA_W    = 8;   // File register and accumulator width
   localparam int FADDR_W   = 7;   // File address, 0 to 127
   localparam int LIT_W     = 11;  // Widest immediate, the branch target
   localparam int PC_W      = 13;  // Program counter width
   localparam int FILE_DEPTH = 128; // File register locations
   localparam int PAGE_W    = 8;   // Page latch width
   // Field positions
   localparam int PC_LOW_HI   = 10; // Top bit loaded from the branch immediate
   localparam int PC_PAGE_HI  = 12; // Program counter page bits 12..11
   localparam int PC_PAGE_LO  = 11;
   localparam int PAGE_SRC_HI = 4;  // Page latch bits 4..3 feed the page bits
   localparam int PAGE_SRC_LO = 3;
   // Reset values
   localparam logic [DATA_W-1:0] W_RESET  = 8'h00;
   localparam logic [PC_W-1:0]   PC_RESET = 13'h0000;
   localparam logic              Z_RESET  = 1'b0;
   // Decoded operations offered to the core
   typedef enum logic [2:0] {
      SBLO_NOP   = 3'h0,
      SBLO_DECSZ = 3'h1, // decrement_skip_if_zero
      SBLO_INCSZ = 3'h2, // increment_skip_if_zero
      SBLO_BR    = 3'h3, // unconditional_branch
      SBLO_ORL   = 3'h4, // or_literal_into_accumulator
      SBLO_ORF   = 3'h5, // or_accumulator_with_file
      SBLO_INCREMENT_FILE_REGISTER  = 3'h6  // increment_file_register
   } sblo_op_t;
   // Core sequencing states
   typedef enum logic [1:0] {
      SBLO_IDLE   = 2'h0, // Ready for an instruction
      SBLO_EXEC   = 2'h1, // File operand arrived, write back
      SBLO_BRANCH = 2'h2, // Second cycle of a branch
      SBLO_SQUASH = 2'h3  // Skipped instruction runs as a no-operation
   } sblo_state_t;
endpackage : sblo_pkg
`default_nettype wire

// [core/sblo_mem_if.sv]
// Interface between the execution core and its file register memory.
// Assumes both ends run on core_clk; read data arrive one edge after the read.
`default_nettype none
interface sblo_mem_if;
   import sblo_pkg::*;
   logic [FADDR_W-1:0] addr;  // Shared read and write address
   logic               rd_en; // Read strobe
   logic               wr_en; // Write strobe
   logic [DATA_W-1:0]  wdata; // Write data
   logic [DATA_W-1:0]  rdata; // Registered read data
   modport core (output addr, rd_en, wr_en, wdata, input rdata);
   modport mem  (input addr, rd_en, wr_en, wdata, output rdata);
endinterface : sblo_mem_if
`default_nettype wire

// [core/sblo_file_mem.sv]
// File register memory: one port, synchronous write, registered read.
// Assumes the core never reads and writes the same cycle with conflicting intent.
`default_nettype none
module sblo_file_mem
   import sblo_pkg::*;
#(
   parameter int DEPTH = FILE_DEPTH,
   parameter int WIDTH = DATA_W
) (
   input  wire logic core_clk,
   sblo_mem_if.mem   bus
);
   // Storage has no reset: contents are undefined until written, like real RAM
   logic [WIDTH-1:0] store [DEPTH];

   // Refuse shapes the core cannot address
   if (DEPTH > (1 << FADDR_W) || WIDTH != DATA_W) begin : g_bad_shape
      $error("sblo_file_mem: unsupported depth or width");
   end

   // Write, then register the read word
   always_ff @(posedge core_clk) begin
      if (bus.wr_en) begin
         store[bus.addr] <= bus.wdata;
      end
      if (bus.rd_en) begin
         bus.rdata <= store[bus.addr];
      end
   end
endmodule : sblo_file_mem
`default_nettype wire

// [test/test_skip_branch_logic_ops_core.sv]
// Self-checking bench for the skip, branch and OR execution core.
// Assumes the core holds its own file memory and that file cells start unknown.
`default_nettype none
module test_skip_branch_logic_ops_core
   import sblo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Expected outcome of one result pulse
   typedef struct packed {
      logic [DATA_W-1:0] res;
      logic [DATA_W-1:0] acc;
      logic              z;
      logic              sk;
   } sblo_note_t;
   logic               core_clk     = 1'b0; // Core clock, 50 ns period
   logic               rst          = 1'b1; // Synchronous reset
   logic               instr_valid  = 1'b0; // Offer strobe
   logic               instr_ready;         // Core can take
   sblo_op_t           instr_op     = SBLO_NOP;
   logic [FADDR_W-1:0] instr_faddr  = 7'h00;
   logic               instr_dest   = 1'b0;
   logic [LIT_W-1:0]   instr_lit    = 11'h000;
   logic [PAGE_W-1:0]  page_latch   = 8'h00;
   logic [DATA_W-1:0]  acc;
   logic               zero_flag;
   logic [PC_W-1:0]    pc;
   logic               skip_pending;
   logic [DATA_W-1:0]  result;
   logic               result_valid;
   int                 errors       = 0;  // Mismatch count
   int                 total_checks = 0;  // Comparison count
   int                 cycles       = 0;  // Watchdog count
   int                 seed_val;          // Holds the seeding call's value
   sblo_note_t         notes[$];          // Expected results, oldest first
   // Reference state kept by the bench
   logic [DATA_W-1:0]  mem_m [FILE_DEPTH];
   logic [DATA_W-1:0]  acc_m;
   logic               z_m;
   logic               skip_m;
   logic [PC_W-1:0]    pc_m;
   logic [FADDR_W-1:0] f;

   sblo_core sblo_core_inst (
      .core_clk     (core_clk),
      .rst          (rst),
      .instr_valid  (instr_valid),
      .instr_ready  (instr_ready),
      .instr_op     (instr_op),
      .instr_faddr  (instr_faddr),
      .instr_dest   (instr_dest),
      .instr_lit    (instr_lit),
      .page_latch   (page_latch),
      .acc          (acc),
      .zero_flag    (zero_flag),
      .pc           (pc),
      .skip_pending (skip_pending),
      .result       (result),
      .result_valid (result_valid)
   );

   // Free-running clock
   always #25 core_clk = ~core_clk;

   // Watchdog: a hung handshake ends the run as a failure
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         final_report();
      end
   end

   // Comparison with four-state equality so an unknown matches only an unknown
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Monitor: sampled at the falling edge, where the pulse is settled
   always @(negedge core_clk) begin
      sblo_note_t n;
      if (!rst && result_valid === 1'b1) begin
         if (notes.size() == 0) begin
            chk("unexpected result", 16'h0, 16'h1);
         end else begin
            n = notes.pop_front();
            chk("result", 16'(n.res), 16'(result));
            chk("acc", 16'(n.acc), 16'(acc));
            chk("zero", 16'(n.z), 16'(zero_flag));
            chk("skip", 16'(n.sk), 16'(skip_pending));
         end
      end
   end

   // Reset values, also after a reset in mid-run
   task automatic chk_reset();
      acc_m = 8'h00; z_m = 1'b0; skip_m = 1'b0; pc_m = PC_RESET;
      chk("acc reset", 16'h0000, 16'(acc));
      chk("zero reset", 16'h0000, 16'(zero_flag));
      chk("pc reset", 16'h0000, 16'(pc));
      chk("skip reset", 16'h0000, 16'(skip_pending));
      chk("ready reset", 16'h0001, 16'(instr_ready));
   endtask

   // Offer one instruction, update the reference, check pc and ready after one cycle
   task automatic issue(sblo_op_t op, logic [6:0] fa, logic d, logic [10:0] lit);
      logic [7:0] r;
      logic [7:0] pg;
      logic       rdy_e;
      int         n;
      pg = 8'($urandom);
      rdy_e = 1'b0;
      instr_op = op; instr_faddr = fa; instr_dest = d; instr_lit = lit;
      page_latch = pg;
      instr_valid = 1'b1;
      n = 0;
      // Wait where ready is settled, then the next edge takes the offer
      while (instr_ready !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      @(posedge core_clk);
      #1 instr_valid = 1'b0;
      if (skip_m) begin
         skip_m = 1'b0; // Squashed slot: only the program counter moves
         pc_m++;
      end else if (op == SBLO_BR) begin
         pc_m = {pg[PAGE_SRC_HI:PAGE_SRC_LO], lit};
      end else if (op == SBLO_ORL || op == SBLO_NOP) begin
         pc_m++;
         rdy_e = 1'b1;
         if (op == SBLO_ORL) begin
            r = acc_m | lit[7:0];
            acc_m = r;
            z_m = (r == 8'h00);
            notes.push_back('{r, acc_m, z_m, skip_m});
         end
      end else begin
         pc_m++;
         case (op)
            SBLO_DECSZ: r = mem_m[fa] - 8'h01;
            SBLO_ORF:   r = acc_m | mem_m[fa];
            default:    r = mem_m[fa] + 8'h01;
         endcase
         if (d) mem_m[fa] = r;
         else acc_m = r;
         if (op == SBLO_ORF || op == SBLO_INCREMENT_FILE_REGISTER) z_m = (r == 8'h00);
         if (op == SBLO_DECSZ || op == SBLO_INCSZ) skip_m = (r == 8'h00);
         notes.push_back('{r, acc_m, z_m, skip_m});
      end
      // One cycle after the take: pc moved, ready low unless a one-cycle op
      chk("pc", 16'(pc_m), 16'(pc));
      chk("ready", 16'(rdy_e), 16'(instr_ready));
      // Let an edge pass so the offer strobe is not rewritten in one step
      @(posedge core_clk);
      #1;
      chk("ready again", 16'h0001, 16'(instr_ready));
   endtask

   // Main sequence
   initial begin
      seed_val = $urandom(32'ha99f);
      repeat (20) @(posedge core_clk);
      #1 rst = 1'b0;
      chk_reset();
      issue(SBLO_ORL, 7'h00, 1'b0, 11'h000);
      issue(SBLO_BR, 7'h00, 1'b0, 11'h7ff);
      for (int i = 0; i < 8; i++) begin
         // Cells start unknown, so all ones OR'd in gives a known value
         f = 7'($urandom);
         issue(SBLO_ORL, f, 1'b0, 11'h0ff);
         issue(SBLO_ORF, f, 1'b1, 11'h000);
         issue(SBLO_INCSZ, f, i[0], 11'h000);
         issue(SBLO_ORL, f, 1'b0, 11'($urandom));
         issue(SBLO_INCREMENT_FILE_REGISTER, f, 1'b1, 11'h000);
         issue(SBLO_DECSZ, f, i[1], 11'h000);
         issue(SBLO_BR, f, 1'b0, 11'($urandom));
         issue(SBLO_ORF, f, i[2], 11'h000);
         issue(SBLO_ORL, f, 1'b0, 11'($urandom));
         issue(SBLO_NOP, f, 1'b0, 11'h000);
      end
      // Reset in mid-run, right after a skip has been armed
      issue(SBLO_ORL, f, 1'b0, 11'h0ff);
      issue(SBLO_ORF, f, 1'b1, 11'h000);
      issue(SBLO_INCSZ, f, 1'b1, 11'h000);
      chk("skip armed", 16'h0001, 16'(skip_pending));
      repeat (3) @(posedge core_clk);
      #1 rst = 1'b1;
      @(posedge core_clk);
      #1 rst = 1'b0;
      chk_reset();
      issue(SBLO_ORL, 7'h00, 1'b0, 11'h05a);
      repeat (3) @(posedge core_clk);
      chk("notes left", 16'h0000, 16'(notes.size()));
      final_report();
   end
endmodule : test_skip_branch_logic_ops_core
`default_nettype wire
